// >>> hw/encoder_pkg.sv
// Constants, field layouts and types for the quadrature encoder counter.
//
// Function
// - 24-bit counter steps up or down.
// - Mode 00: A clocks, B gives direction.
// - Mode 01: one count per four transitions.
// - Mode 10: one count per two transitions.
// - Mode 11: one count per transition.
// - Bits 17:16 select the counting mode.
// - Bit 19 swaps inputs A and B.
// - Counter counts only while bit 18 set.
// - Limit compare stops, clears or reloads counter.
// - Writing the capture register latches count.
// - Global write latches all four channels.
// - Separate compare value works in every mode.
// - Match trigger latches own or other channels.
// - Sticky flags clear by writing one.
// - Seven selectable channel trigger conditions.
// - Channel triggers ORed into combined trigger.
// - Combined trigger latches enabled channels.
// - Channel bases 0, 8, 16, 48.
// - Writing zero to reserved bits does nothing.
package encoder_pkg;

    // ==========================================================
    // Sizes
    localparam int CH_NUM = 4;
    localparam int CNT_W = 24;
    localparam int DATA_W = 32;
    localparam int ADDR_W = 6;
    localparam int EV_W = 7;
    localparam logic [CNT_W-1:0] CNT_MAX = 24'hFFFFFF;

    // ==========================================================
    // Register numbers
    localparam logic [ADDR_W-1:0] CH_BASE [CH_NUM] =
        '{6'h00, 6'h08, 6'h10, 6'h30};
    localparam logic [ADDR_W-1:0] OFS_LIMIT = 6'h00;
    localparam logic [ADDR_W-1:0] OFS_CAPTURE = 6'h01;
    localparam logic [ADDR_W-1:0] OFS_COMPARE = 6'h02;
    localparam logic [ADDR_W-1:0] OFS_SETUP = 6'h03;
    localparam logic [ADDR_W-1:0] OFS_FLAGS = 6'h04;
    localparam logic [ADDR_W-1:0] REG_GLOBAL = 6'h07;

    // ==========================================================
    // Channel setup fields
    localparam int SETUP_TRIG_LSB = 0;
    localparam int SETUP_QUAD_LSB = 14;
    localparam int SETUP_MODE_LSB = 16;
    localparam int SETUP_ENABLE_BIT = 18;
    localparam int SETUP_SWAP_BIT = 19;
    localparam int SETUP_OWN_LATCH_BIT = 22;
    localparam int SETUP_COMB_LATCH_BIT = 23;
    localparam logic [DATA_W-1:0] SETUP_MASK = 32'h00CFC07F;

    // ==========================================================
    // Event positions, shared by trigger enables and flags
    localparam int EV_FWD = 0;
    localparam int EV_BACK = 1;
    localparam int EV_ZERO = 2;
    localparam int EV_INDEX = 3;
    localparam int EV_MATCH = 4;
    localparam int EV_CARRY = 5;
    localparam int EV_BORROW = 6;
    localparam logic [EV_W-1:0] FLAG_STICKY_MASK = 7'h7C;
    localparam int FLAG_DIR_BIT = 7;
    localparam int FLAG_HALT_BIT = 8;

    // Global register: bits 3:0 clear the counters of channels 3..0.
    localparam int GLOBAL_CLEAR_LSB = 0;

    // ==========================================================
    // Reset values
    localparam logic [CNT_W-1:0] RST_LIMIT = 24'h000000;
    localparam logic [CNT_W-1:0] RST_COMPARE = 24'h000000;
    localparam logic [DATA_W-1:0] RST_SETUP = 32'h00000000;

    typedef enum logic [1:0] {
        QUAD_CLKDIR = 2'b00,
        QUAD_X1 = 2'b01,
        QUAD_X2 = 2'b10,
        QUAD_X4 = 2'b11
    } quad_e;

    typedef enum logic [1:0] {
        MODE_PLAIN = 2'b00,
        MODE_RANGE = 2'b01,
        MODE_NORECYCLE = 2'b10,
        MODE_MODULO = 2'b11
    } count_mode_e;

endpackage : encoder_pkg

// >>> hw/quad_step_decoder.sv
// Quadrature and clock/direction step decoder for one channel.
`timescale 1ns/1ps
module quad_step_decoder
    import encoder_pkg::*;
(
    input wire logic mclk_i, // System clock.
    input wire logic reset_i, // Synchronous reset, high.
    input wire logic ce_i, // Clock enable.
    input wire logic a_i, // Input A after swap.
    input wire logic b_i, // Input B after swap.
    input wire quad_e quad_i, // Decoding mode.
    output logic fwd_o, // Forward step pulse.
    output logic back_o // Backward step pulse.
);

    logic a_q, b_q, a_d, b_d;
    logic primed_q, primed_d;
    logic a_chg, b_chg, one_chg, dir_fwd;

    always_comb begin
        a_d = a_i;
        b_d = b_i;
        primed_d = 1'b1;
        a_chg = primed_q & (a_q ^ a_i);
        b_chg = primed_q & (b_q ^ b_i);
        one_chg = a_chg ^ b_chg;
        // Forward means A leads B: old A equals new B on a legal step.
        dir_fwd = ~(a_q ^ b_i);
        fwd_o = 1'b0;
        back_o = 1'b0;
        unique case (quad_i)
            QUAD_CLKDIR: begin
                fwd_o = a_chg & a_i & b_i;
                back_o = a_chg & a_i & ~b_i;
            end
            QUAD_X1: begin
                // Only the A edge with B low counts, one of four states.
                fwd_o = one_chg & a_chg & ~b_i & a_i;
                back_o = one_chg & a_chg & ~b_i & ~a_i;
            end
            QUAD_X2: begin
                fwd_o = one_chg & a_chg & dir_fwd;
                back_o = one_chg & a_chg & ~dir_fwd;
            end
            QUAD_X4: begin
                fwd_o = one_chg & dir_fwd;
                back_o = one_chg & ~dir_fwd;
            end
        endcase
    end

    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            a_q <= 1'b0;
            b_q <= 1'b0;
            primed_q <= 1'b0;
        end else if (ce_i) begin
            a_q <= a_d;
            b_q <= b_d;
            primed_q <= primed_d;
        end
    end

endmodule : quad_step_decoder

// >>> hw/position_counter_core.sv
// 24-bit position counter with limit modes and event outputs.
`timescale 1ns/1ps
module position_counter_core
    import encoder_pkg::*;
(
    input wire logic mclk_i, // System clock.
    input wire logic reset_i, // Synchronous reset, high.
    input wire logic ce_i, // Clock enable.
    input wire logic enable_i, // Counting enabled.
    input wire count_mode_e mode_i, // Counting mode.
    input wire logic [CNT_W-1:0] limit_i, // Upper limit.
    input wire logic [CNT_W-1:0] compare_i, // Match value.
    input wire logic fwd_i, // Forward step pulse.
    input wire logic back_i, // Backward step pulse.
    input wire logic index_i, // Index input level.
    input wire logic clear_i, // Clear count and halt.
    output logic [CNT_W-1:0] count_o, // Current count.
    output logic [EV_W-1:0] events_o, // One-cycle event pulses.
    output logic dir_o, // Last direction, 1 forward.
    output logic halted_o // Non-recycle halt state.
);

    logic [CNT_W-1:0] count_q, count_d;
    logic halted_q, halted_d, dir_q, dir_d, idx_q, idx_d;
    logic up, dn, carry, borrow, step;

    always_comb begin
        up = enable_i & fwd_i & ~halted_q;
        dn = enable_i & back_i & ~halted_q;
        count_d = count_q;
        halted_d = halted_q;
        dir_d = up ? 1'b1 : (dn ? 1'b0 : dir_q);
        idx_d = index_i;
        carry = 1'b0;
        borrow = 1'b0;
        if (up) begin
            count_d = CNT_W'(count_q + 1'b1);
            unique case (mode_i)
                MODE_PLAIN: carry = (count_q == CNT_MAX);
                MODE_RANGE: begin
                    carry = (count_q >= limit_i);
                    if (carry) count_d = count_q;
                end
                MODE_NORECYCLE, MODE_MODULO: begin
                    carry = (count_q >= limit_i);
                    if (carry) count_d = '0;
                end
            endcase
        end else if (dn) begin
            count_d = CNT_W'(count_q - 1'b1);
            borrow = (count_q == '0);
            if (borrow) begin
                unique case (mode_i)
                    MODE_PLAIN: count_d = CNT_MAX;
                    MODE_RANGE: count_d = count_q;
                    MODE_NORECYCLE, MODE_MODULO: count_d = limit_i;
                endcase
            end
        end
        if (mode_i == MODE_NORECYCLE && (carry || borrow)) begin
            halted_d = 1'b1;
        end
        step = (up | dn) & (count_d != count_q);
        events_o = '0;
        events_o[EV_FWD] = up;
        events_o[EV_BACK] = dn;
        events_o[EV_ZERO] = step & (count_d == '0);
        events_o[EV_INDEX] = index_i & ~idx_q;
        events_o[EV_MATCH] = step & (count_d == compare_i);
        events_o[EV_CARRY] = carry;
        events_o[EV_BORROW] = borrow;
        if (clear_i) begin
            count_d = '0;
            halted_d = 1'b0;
        end
    end

    assign count_o = count_q;
    assign dir_o = dir_q;
    assign halted_o = halted_q;

    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            count_q <= '0;
            halted_q <= 1'b0;
            dir_q <= 1'b1;
            idx_q <= 1'b0;
        end else if (ce_i) begin
            count_q <= count_d;
            halted_q <= halted_d;
            dir_q <= dir_d;
            idx_q <= idx_d;
        end
    end

endmodule : position_counter_core

// >>> hw/quadrature_encoder_counter.sv
// Four-channel encoder counter with registers, latches and triggers.
`timescale 1ns/1ps
module quadrature_encoder_counter
    import encoder_pkg::*;
(
    input wire logic mclk_i, // System clock, 25 MHz.
    input wire logic reset_i, // Synchronous reset, high.
    input wire logic ce_i, // Clock enable, freezes all state.
    input wire logic [CH_NUM-1:0] enc_a_i, // Encoder A inputs.
    input wire logic [CH_NUM-1:0] enc_b_i, // Encoder B inputs.
    input wire logic [CH_NUM-1:0] enc_idx_i, // Encoder index inputs.
    input wire logic [ADDR_W-1:0] reg_addr_i, // Register number.
    input wire logic reg_wr_i, // Write strobe.
    input wire logic reg_rd_i, // Read strobe.
    input wire logic [DATA_W-1:0] reg_wdata_i, // Write data.
    output logic [DATA_W-1:0] reg_rdata_o, // Read data, registered.
    output logic [CH_NUM-1:0] chan_trig_o, // Per-channel trigger.
    output logic trig_combined_o // Combined trigger.
);

    // ==========================================================
    // Address decoding

    // One bit per channel whose register at the given offset is addressed.
    function automatic logic [CH_NUM-1:0] chan_hit(
        input logic [ADDR_W-1:0] addr,
        input logic [ADDR_W-1:0] ofs
    );
        logic [CH_NUM-1:0] hit;
        hit = '0;
        for (int c = 0; c < CH_NUM; c++) begin
            hit[c] = (addr == ADDR_W'(CH_BASE[c] + ofs));
        end
        return hit;
    endfunction : chan_hit

    logic [CH_NUM-1:0] wr_limit, wr_capture, wr_compare;
    logic [CH_NUM-1:0] wr_setup, wr_flags;
    logic wr_global;

    always_comb begin
        wr_limit = reg_wr_i ? chan_hit(reg_addr_i, OFS_LIMIT) : '0;
        wr_capture = reg_wr_i ? chan_hit(reg_addr_i, OFS_CAPTURE) : '0;
        wr_compare = reg_wr_i ? chan_hit(reg_addr_i, OFS_COMPARE) : '0;
        wr_setup = reg_wr_i ? chan_hit(reg_addr_i, OFS_SETUP) : '0;
        wr_flags = reg_wr_i ? chan_hit(reg_addr_i, OFS_FLAGS) : '0;
        wr_global = reg_wr_i & (reg_addr_i == REG_GLOBAL);
    end

    // ==========================================================
    // Per-channel state, gathered for the read mux

    logic [CNT_W-1:0] rd_limit [CH_NUM];
    logic [CNT_W-1:0] rd_capture [CH_NUM];
    logic [CNT_W-1:0] rd_compare [CH_NUM];
    logic [DATA_W-1:0] rd_setup [CH_NUM];
    logic [DATA_W-1:0] rd_flags [CH_NUM];

    // The combined trigger is combinational so that every channel with bit 23 set latches
    // in the same cycle as the event that caused it.
    assign trig_combined_o = |chan_trig_o;

    for (genvar g = 0; g < CH_NUM; g++) begin : gen_ch
        logic [CNT_W-1:0] limit_q, limit_d;
        logic [CNT_W-1:0] compare_q, compare_d;
        logic [CNT_W-1:0] capture_q, capture_d;
        logic [DATA_W-1:0] setup_q, setup_d;
        logic [EV_W-1:0] flags_q, flags_d;
        logic [CNT_W-1:0] count;
        logic [EV_W-1:0] events;
        logic dir, halted, fwd, back, a_in, b_in, clear, grab;

        // Swapping A and B reverses the decoded direction in the quadrature modes; in mode 00 it makes B the clock.
        assign a_in = setup_q[SETUP_SWAP_BIT] ? enc_b_i[g] : enc_a_i[g];
        assign b_in = setup_q[SETUP_SWAP_BIT] ? enc_a_i[g] : enc_b_i[g];

        quad_step_decoder u_dec (
            .mclk_i(mclk_i),
            .reset_i(reset_i),
            .ce_i(ce_i),
            .a_i(a_in),
            .b_i(b_in),
            .quad_i(quad_e'(setup_q[SETUP_QUAD_LSB +: 2])),
            .fwd_o(fwd),
            .back_o(back)
        );

        assign clear = wr_global & reg_wdata_i[GLOBAL_CLEAR_LSB + g];

        position_counter_core u_core (
            .mclk_i(mclk_i),
            .reset_i(reset_i),
            .ce_i(ce_i),
            .enable_i(setup_q[SETUP_ENABLE_BIT]),
            .mode_i(count_mode_e'(setup_q[SETUP_MODE_LSB +: 2])),
            .limit_i(limit_q),
            .compare_i(compare_q),
            .fwd_i(fwd),
            .back_i(back),
            .index_i(enc_idx_i[g]),
            .clear_i(clear),
            .count_o(count),
            .events_o(events),
            .dir_o(dir),
            .halted_o(halted)
        );

        // Selected conditions leave the channel as its trigger.
        assign chan_trig_o[g] =
            |(events & setup_q[SETUP_TRIG_LSB +: EV_W]);

        // Any of the four capture sources loads the latch.
        assign grab = wr_capture[g]
            | wr_global
            | (chan_trig_o[g] & setup_q[SETUP_OWN_LATCH_BIT])
            | (trig_combined_o & setup_q[SETUP_COMB_LATCH_BIT]);

        always_comb begin
            limit_d = wr_limit[g] ? reg_wdata_i[CNT_W-1:0] : limit_q;
            compare_d = wr_compare[g] ? reg_wdata_i[CNT_W-1:0] : compare_q;
            capture_d = grab ? count : capture_q;
            // Bits outside the mask are reserved and never change.
            setup_d = wr_setup[g] ? (reg_wdata_i & SETUP_MASK)
                                  : setup_q;
            // A new event wins over a clear in the same cycle.
            flags_d = flags_q;
            if (wr_flags[g]) begin
                flags_d = flags_q & ~(reg_wdata_i[EV_W-1:0]);
            end
            flags_d = (flags_d | events) & FLAG_STICKY_MASK;
        end

        always_ff @(posedge mclk_i) begin
            if (reset_i) begin
                limit_q <= RST_LIMIT;
                compare_q <= RST_COMPARE;
                capture_q <= '0;
                setup_q <= RST_SETUP;
                flags_q <= '0;
            end else if (ce_i) begin
                limit_q <= limit_d;
                compare_q <= compare_d;
                capture_q <= capture_d;
                setup_q <= setup_d;
                flags_q <= flags_d;
            end
        end

        assign rd_limit[g] = limit_q;
        assign rd_capture[g] = capture_q;
        assign rd_compare[g] = compare_q;
        assign rd_setup[g] = setup_q;
        always_comb begin
            rd_flags[g] = '0;
            rd_flags[g][EV_W-1:0] = flags_q;
            rd_flags[g][FLAG_DIR_BIT] = dir;
            rd_flags[g][FLAG_HALT_BIT] = halted;
        end
    end

    // ==========================================================
    // Read path

    logic [DATA_W-1:0] rdata_q, rdata_d, rsel;
    logic [CH_NUM-1:0] h_lim, h_cap, h_cmp, h_set, h_flg;

    // Reads never disturb the latch; a capture needs a write or a trigger.
    always_comb begin
        h_lim = chan_hit(reg_addr_i, OFS_LIMIT);
        h_cap = chan_hit(reg_addr_i, OFS_CAPTURE);
        h_cmp = chan_hit(reg_addr_i, OFS_COMPARE);
        h_set = chan_hit(reg_addr_i, OFS_SETUP);
        h_flg = chan_hit(reg_addr_i, OFS_FLAGS);
        rsel = '0;
        for (int c = 0; c < CH_NUM; c++) begin
            if (h_lim[c]) rsel = {8'h00, rd_limit[c]};
            if (h_cap[c]) rsel = {8'h00, rd_capture[c]};
            if (h_cmp[c]) rsel = {8'h00, rd_compare[c]};
            if (h_set[c]) rsel = rd_setup[c];
            if (h_flg[c]) rsel = rd_flags[c];
        end
        rdata_d = reg_rd_i ? rsel : rdata_q;
    end

    assign reg_rdata_o = rdata_q;

    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            rdata_q <= '0;
        end else if (ce_i) begin
            rdata_q <= rdata_d;
        end
    end

endmodule : quadrature_encoder_counter

// >>> testbench/encoder_checker.sv
// Port-level assertions for the encoder counter block.
`timescale 1ns/1ps
module encoder_checker
    import encoder_pkg::*;
(
    input wire logic mclk_i, // Clock.
    input wire logic reset_i, // Reset.
    input wire logic ce_i, // Clock enable.
    input wire logic [CH_NUM-1:0] enc_a_i, // Phase A.
    input wire logic [CH_NUM-1:0] enc_b_i, // Phase B.
    input wire logic [CH_NUM-1:0] enc_idx_i, // Index.
    input wire logic [ADDR_W-1:0] reg_addr_i, // Register number.
    input wire logic reg_wr_i, // Write strobe.
    input wire logic reg_rd_i, // Read strobe.
    input wire logic [DATA_W-1:0] reg_wdata_i, // Write data.
    input wire logic [DATA_W-1:0] reg_rdata_o, // Read data.
    input wire logic [CH_NUM-1:0] chan_trig_o, // Channel triggers.
    input wire logic trig_combined_o // Combined trigger.
);
    logic rd;
    logic chsel;
    assign rd = ce_i && reg_rd_i;
    assign chsel = reg_addr_i[5:3] inside {3'h0, 3'h1, 3'h2, 3'h6};

    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (reset_i);

    // ==========================================================
    // Triggers
    property p_or;
        trig_combined_o == |chan_trig_o;
    endproperty
    a_or: assert property (p_or) else $error("combined trigger");
    // Events need a step or an index edge, so quiet inputs give no trigger.
    property p_quiet;
        (ce_i && $stable(enc_a_i) && $stable(enc_b_i)
            && $stable(enc_idx_i))[*3] |-> chan_trig_o == '0;
    endproperty
    a_quiet: assert property (p_quiet) else $error("stray trig");

    // ==========================================================
    // Register reads
    property p_glob;
        rd && reg_addr_i == REG_GLOBAL |=> reg_rdata_o == '0;
    endproperty
    a_glob: assert property (p_glob) else $error("global read");
    property p_hold;
        !rd |=> $stable(reg_rdata_o);
    endproperty
    a_hold: assert property (p_hold) else $error("rdata moved");
    property p_unmap;
        rd && reg_addr_i != REG_GLOBAL && (!chsel || reg_addr_i[2:0] > 3'h4)
            |=> reg_rdata_o == '0;
    endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped");
    property p_mask;
        rd && chsel && reg_addr_i[2:0] == 3'h3
            |=> (reg_rdata_o & ~SETUP_MASK) == '0;
    endproperty
    a_mask: assert property (p_mask) else $error("setup bits");
    property p_upper;
        rd && chsel && reg_addr_i[2:0] < 3'h3 |=> reg_rdata_o[31:24] == '0;
    endproperty
    a_upper: assert property (p_upper) else $error("upper bits");
    property p_flags;
        rd && chsel && reg_addr_i[2:0] == 3'h4
            |=> reg_rdata_o[1:0] == '0 && reg_rdata_o[31:9] == '0;
    endproperty
    a_flags: assert property (p_flags) else $error("flag bits");
endmodule : encoder_checker

// >>> testbench/quad_encoder_model.sv
// Behavioural model of four incremental encoders.
`timescale 1ns/1ps
module quad_encoder_model
    import encoder_pkg::*;
(
    input wire logic mclk_i, // Bench clock.
    output logic [CH_NUM-1:0] a_o, // Phase A.
    output logic [CH_NUM-1:0] b_o, // Phase B.
    output logic [CH_NUM-1:0] idx_o // Index, pulsed on demand.
);
    logic [1:0] phase_q [CH_NUM];

    initial begin
        a_o = '0;
        b_o = '0;
        idx_o = '0;
        foreach (phase_q[i]) phase_q[i] = 2'h0;
    end

    // Each state stands three cycles, so A and B never move together.
    task automatic step(input int ch, input bit fwd, input int n);
        repeat (n) begin
            phase_q[ch] = fwd ? phase_q[ch] + 2'h1 : phase_q[ch] - 2'h1;
            @(posedge mclk_i);
            a_o[ch] <= phase_q[ch][1] ^ phase_q[ch][0];
            b_o[ch] <= phase_q[ch][1];
            repeat (2) @(posedge mclk_i);
        end
    endtask : step

    task automatic clk_dir(input int ch, input bit up, input int n);
        @(posedge mclk_i);
        b_o[ch] <= up;
        repeat (n) begin
            repeat (2) @(posedge mclk_i);
            a_o[ch] <= 1'b1;
            repeat (2) @(posedge mclk_i);
            a_o[ch] <= 1'b0;
        end
        repeat (2) @(posedge mclk_i);
        phase_q[ch] = up ? 2'h3 : 2'h0;
    endtask : clk_dir

    // One-cycle index pulse, launched just after a clock edge.
    task automatic index(input int ch);
        @(posedge mclk_i);
        idx_o[ch] <= 1'b1;
        @(posedge mclk_i);
        idx_o[ch] <= 1'b0;
    endtask : index
endmodule : quad_encoder_model

// >>> testbench/tb_quadrature_encoder_counter.sv
// Self-checking bench for the four-channel encoder counter.
`timescale 1ns/1ps
module tb_quadrature_encoder_counter import encoder_pkg::*;;
    logic mclk_i;
    logic reset_i;
    logic ce_i;
    logic reg_wr_i;
    logic reg_rd_i;
    logic [ADDR_W-1:0] reg_addr_i;
    logic [DATA_W-1:0] reg_wdata_i;
    logic [DATA_W-1:0] reg_rdata_o;
    logic [CH_NUM-1:0] enc_a_i;
    logic [CH_NUM-1:0] enc_b_i;
    logic [CH_NUM-1:0] enc_idx_i;
    logic [CH_NUM-1:0] chan_trig_o;
    logic trig_combined_o;
    int n_fail;
    int tests_run;
    int n_trig;
    int cycles;

    quad_encoder_model enc_u (.mclk_i(mclk_i), .a_o(enc_a_i),
        .b_o(enc_b_i), .idx_o(enc_idx_i));
    quadrature_encoder_counter dut_u (.mclk_i(mclk_i), .reset_i(reset_i),
        .ce_i(ce_i), .enc_a_i(enc_a_i), .enc_b_i(enc_b_i),
        .enc_idx_i(enc_idx_i), .reg_addr_i(reg_addr_i),
        .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
        .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
        .chan_trig_o(chan_trig_o), .trig_combined_o(trig_combined_o));

    initial begin
        mclk_i = 1'b0;
        forever #20 mclk_i = ~mclk_i;
    end

    // The whole run needs about 420 cycles; the ceiling leaves margin.
    always @(posedge mclk_i) begin
        cycles++;
        if (trig_combined_o === 1'b1) n_trig++;
        if (cycles == 20000) begin
            n_fail++;
            end_of_test();
        end
    end

    // ==========================================================
    // Bus and compare tasks
    task automatic chk(input string what, input logic [31:0] exp,
        input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
        @(posedge mclk_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        @(posedge mclk_i);
        reg_wr_i <= 1'b0;
    endtask : wr

    task automatic rdchk(input logic [ADDR_W-1:0] a, input logic [31:0] exp,
        input logic [31:0] mask, input string what);
        @(posedge mclk_i);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge mclk_i);
        reg_rd_i <= 1'b0;
        @(negedge mclk_i);
        chk(what, exp, reg_rdata_o & mask);
    endtask : rdchk

    task automatic cap(input int ch, input logic [31:0] exp, input string s);
        repeat (3) @(posedge mclk_i);
        wr(CH_BASE[ch] + OFS_CAPTURE, 32'h0);
        rdchk(CH_BASE[ch] + OFS_CAPTURE, exp, '1, s);
    endtask : cap

    task automatic setup(input int ch, input logic [31:0] v);
        wr(CH_BASE[ch] + OFS_SETUP, v);
    endtask : setup

    task automatic clr(input logic [3:0] m);
        wr(REG_GLOBAL, {28'h0, m});
    endtask : clr

    function automatic logic [31:0] cfg(input quad_e q, input count_mode_e m);
        return 32'h00040000 | (32'(q) << SETUP_QUAD_LSB)
            | (32'(m) << SETUP_MODE_LSB);
    endfunction : cfg

    // ==========================================================
    // Scenarios
    task automatic t_regs();
        rdchk(6'h03, 32'h0, '1, "setup reset");
        wr(6'h13, 32'hFFFFFFFF);
        rdchk(6'h13, SETUP_MASK, '1, "setup mask");
        wr(6'h13, 32'h0);
        rdchk(6'h05, 32'h0, '1, "unmapped");
        rdchk(REG_GLOBAL, 32'h0, '1, "global read");
        $display("TB: registers done");
    endtask : t_regs

    task automatic t_count();
        setup(0, 32'h0000C000);
        enc_u.step(0, 1, 3);
        cap(0, 32'h0, "disabled");
        setup(0, cfg(QUAD_X4, MODE_PLAIN));
        enc_u.step(0, 1, 5);
        enc_u.step(0, 0, 2);
        cap(0, 32'h3, "x4 up down");
        enc_u.step(0, 1, 2);
        rdchk(6'h01, 32'h3, '1, "capture held");
        $display("TB: counting done");
    endtask : t_count

    task automatic t_decode();
        for (int i = 1; i < 4; i++) begin
            setup(0, cfg(quad_e'(i), MODE_PLAIN));
            clr(4'h1);
            enc_u.step(0, 1, 8);
            cap(0, 32'h2 << (i - 1), "decode");
        end
        setup(0, cfg(QUAD_CLKDIR, MODE_PLAIN));
        clr(4'h1);
        enc_u.clk_dir(0, 1, 3);
        enc_u.clk_dir(0, 0, 2);
        cap(0, 32'h1, "clock dir");
        setup(0, cfg(QUAD_X4, MODE_PLAIN) | 32'h00080000);
        clr(4'h1);
        enc_u.step(0, 1, 4);
        cap(0, 32'hFFFFFC, "swap wrap");
        $display("TB: decoding done");
    endtask : t_decode

    task automatic t_limits();
        wr(6'h00, 32'h3);
        setup(0, cfg(QUAD_X4, MODE_MODULO));
        clr(4'h1);
        wr(6'h04, 32'h7C);
        enc_u.step(0, 1, 5);
        cap(0, 32'h1, "modulo");
        rdchk(6'h04, 32'h20, 32'h20, "carry flag");
        wr(6'h04, 32'h20);
        rdchk(6'h04, 32'h0, 32'h20, "carry clear");
        setup(0, cfg(QUAD_X4, MODE_RANGE));
        clr(4'h1);
        enc_u.step(0, 1, 6);
        cap(0, 32'h3, "range");
        setup(0, cfg(QUAD_X4, MODE_NORECYCLE));
        clr(4'h1);
        enc_u.step(0, 1, 5);
        cap(0, 32'h0, "no recycle");
        rdchk(6'h04, 32'h100, 32'h100, "halted");
        enc_u.index(0);
        rdchk(6'h04, 32'h8, 32'h8, "index flag");
        $display("TB: limits done");
    endtask : t_limits

    task automatic t_global();
        for (int k = 0; k < CH_NUM; k++)
            setup(k, cfg(QUAD_X4, MODE_PLAIN));
        clr(4'hF);
        for (int k = 0; k < CH_NUM; k++)
            enc_u.step(k, 1, k + 1);
        repeat (3) @(posedge mclk_i);
        clr(4'h0);
        for (int k = 0; k < CH_NUM; k++)
            rdchk(CH_BASE[k] + OFS_CAPTURE, k + 1, '1, "all");
        $display("TB: global latch done");
    endtask : t_global

    task automatic t_trigger();
        clr(4'hF);
        // The latch takes the count standing in the match cycle, one step
        // short of the compare value, so it differs from the stale capture.
        wr(6'h02, 32'h3);
        setup(0, cfg(QUAD_X4, MODE_MODULO) | 32'h00400010);
        setup(1, cfg(QUAD_X4, MODE_PLAIN) | 32'h00800000);
        n_trig = 0;
        enc_u.step(1, 1, 1);
        enc_u.step(0, 1, 3);
        enc_u.step(1, 1, 1);
        repeat (3) @(posedge mclk_i);
        chk("trigger pulses", 32'h1, n_trig);
        rdchk(6'h01, 32'h2, '1, "own latch");
        rdchk(6'h09, 32'h1, '1, "combined latch");
        $display("TB: triggers done");
    endtask : t_trigger

    task automatic end_of_test();
        $display("TB: %0d checks, %0d mismatches", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : end_of_test

    initial begin
        reset_i = 1'b1;
        ce_i = 1'b1;
        reg_wr_i = 1'b0;
        reg_rd_i = 1'b0;
        reg_addr_i = '0;
        reg_wdata_i = '0;
        n_fail = 0;
        tests_run = 0;
        n_trig = 0;
        cycles = 0;
        repeat (5) @(posedge mclk_i);
        reset_i <= 1'b0;
        t_regs();
        t_count();
        t_decode();
        t_limits();
        t_global();
        t_trigger();
        end_of_test();
    end
endmodule : tb_quadrature_encoder_counter

bind quadrature_encoder_counter encoder_checker chk_u (.mclk_i(mclk_i),
    .reset_i(reset_i), .ce_i(ce_i), .enc_a_i(enc_a_i), .enc_b_i(enc_b_i),
    .enc_idx_i(enc_idx_i), .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_wdata_i(reg_wdata_i),
    .reg_rdata_o(reg_rdata_o), .chan_trig_o(chan_trig_o),
    .trig_combined_o(trig_combined_o));
